// file: hw/mftimer.v
/*
  two-counter multifunction timer: pulse-train pwm, dual-input capture
  and dual independent timer modes, with register port and interrupts.
  assumes pin_a_in and pin_b_in come from pads outside the sys_clk
  domain; register port master runs on sys_clk.
*/
// Functional notes
// - pulse train needs pwm mode plus enable bit
// - counter one reloads alternately a then b
// - each counter one underflow decrements counter two
// - counter two underflow stops counter one clock
// - counter two presets to zero in train
// - start on pin b edge or software trigger
// - disabled at reset; first reload from a
// - counter two not reloaded after train end
// - pulses equal counter two value plus one
// - edge select bits choose rising or falling
// - reloads set reload a or b pending
// - pin edges capture counter one into a/b
// - capture then preset counter to all ones
// - capture a, b, underflow set own flags
// - counter two is system timer, flag d
// - capture: pin-b clock sources stop counter one
// - dual timer: one reloads a, toggles pin a
// - dual timer: two reloads b, flag d
// - pin b clocks either counter in dual mode
// - software picks initial pin a level
// - counters and reload registers sixteen bits
`include "mftimer_consts.vh"
`default_nettype none

module mftimer (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [31:0] rdata,
  input wire pin_a_in,
  input wire pin_b_in,
  output wire pwm_output_pad,
  output wire irq_a,
  output wire irq_b
);

  // picks the count tick for a clock selector code
  function clk_tick;
    input [2:0] sel;
    input pre_tick;
    input b_edge;
    input b_active;
    begin
      case (sel)
        `CK_PRESCALED: clk_tick = pre_tick;
        `CK_EXT_EVENT: clk_tick = b_edge;
        `CK_PULSE_ACC: clk_tick = pre_tick & b_active;
        default: clk_tick = 1'b0;
      endcase
    end
  endfunction

  // edge detector with polarity select
  function edge_hit;
    input now;
    input prev;
    input falling;
    begin
      edge_hit = falling ? (prev & ~now) : (now & ~prev);
    end
  endfunction

  reg [10:0] mode_ctrl_reg;
  reg [15:0] clock_ctrl_reg;
  reg [15:0] counter_one_reg;
  reg [15:0] counter_two_reg;
  reg [15:0] reload_capture_a_reg;
  reg [15:0] reload_capture_b_reg;
  reg [3:0] irq_enable_reg;
  reg [3:0] pending_reg;
  reg pin_a_level_reg;
  reg reload_from_b_reg;
  reg train_run_reg;
  reg [7:0] prescale_cnt_reg;
  reg pa_meta_reg, pa_sync_reg, pa_prev_reg;
  reg pb_meta_reg, pb_sync_reg, pb_prev_reg;

  wire [1:0] mode_select_field = mode_ctrl_reg[`MC_MODE_HI:`MC_MODE_LO];
  wire pulse_train_enable = mode_ctrl_reg[`MC_PT_EN];
  wire timer_enable_bit = mode_ctrl_reg[`MC_TIMER_EN];
  wire pulse_train_sw_select = mode_ctrl_reg[`MC_PT_SW_SEL];
  wire edge_select_a = mode_ctrl_reg[`MC_EDGE_A];
  wire edge_select_b = mode_ctrl_reg[`MC_EDGE_B];
  wire pin_a_function_enable = mode_ctrl_reg[`MC_PIN_A_FN];
  wire pin_b_function_enable = mode_ctrl_reg[`MC_PIN_B_FN];
  wire [2:0] clock_sel_one = clock_ctrl_reg[`CC_SEL1_HI:`CC_SEL1_LO];
  wire [2:0] clock_sel_two = clock_ctrl_reg[`CC_SEL2_HI:`CC_SEL2_LO];
  wire [7:0] prescale_value = clock_ctrl_reg[`CC_PRE_HI:`CC_PRE_LO];

  wire wr_mode = wr_strobe & (addr == `OFS_MODE_CTRL);
  wire wr_clock = wr_strobe & (addr == `OFS_CLOCK_CTRL);
  wire wr_cnt_one = wr_strobe & (addr == `OFS_COUNTER_ONE);
  wire wr_cnt_two = wr_strobe & (addr == `OFS_COUNTER_TWO);
  wire wr_rel_a = wr_strobe & (addr == `OFS_RELOAD_A);
  wire wr_rel_b = wr_strobe & (addr == `OFS_RELOAD_B);
  wire wr_ien = wr_strobe & (addr == `OFS_IRQ_ENABLE);
  wire wr_pend = wr_strobe & (addr == `OFS_PENDING);

  wire mode_pwm = timer_enable_bit & (mode_select_field == `MODE_PWM);
  wire mode_train = mode_pwm & pulse_train_enable;
  wire mode_capture = timer_enable_bit &
    (mode_select_field == `MODE_CAPTURE);
  wire mode_dual = timer_enable_bit & (mode_select_field == `MODE_DUAL);

  // only synchroniser second stages feed the edge logic
  wire edge_a = edge_hit(pa_sync_reg, pa_prev_reg,
    edge_select_a);
  wire edge_b = edge_hit(pb_sync_reg, pb_prev_reg,
    edge_select_b);
  wire b_active = pb_sync_reg ^ edge_select_b;
  wire pre_tick = (prescale_cnt_reg == prescale_value[7:0]);

  // pulse-train start source
  wire sw_trigger = wr_mode & wdata[`MC_PT_SW_TRIG] &
    wdata[`MC_TIMER_EN];
  wire train_start = mode_train & ~train_run_reg &
    (pulse_train_sw_select ? sw_trigger : edge_b);

  // counter one tick per mode
  wire tick_one_raw = clk_tick(clock_sel_one, pre_tick, edge_b, b_active);
  wire tick_one_cap = (clock_sel_one == `CK_PRESCALED) &
    pre_tick;
  wire tick_one = mode_train ? (train_run_reg & tick_one_raw) :
    mode_capture ? tick_one_cap :
    (mode_pwm | mode_dual) ? tick_one_raw : 1'b0;
  wire tick_two = (mode_dual | mode_capture | (mode_pwm & ~mode_train)) &
    clk_tick(clock_sel_two, pre_tick, edge_b, b_active);
  wire uf_one = tick_one & (counter_one_reg == `CNT_ZERO);
  wire uf_two = tick_two & (counter_two_reg == `CNT_ZERO);
  wire train_end = mode_train & uf_one &
    (counter_two_reg == `CNT_ZERO);

  assign pwm_output_pad = pin_a_level_reg;
  assign irq_a = |(pending_reg[`PN_C:`PN_A] &
    irq_enable_reg[`PN_C:`PN_A]);
  assign irq_b = pending_reg[`PN_D] & irq_enable_reg[`PN_D];

  // two-flop synchronisers and edge history
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_meta_reg <= 1'b0;
      pa_sync_reg <= 1'b0;
      pa_prev_reg <= 1'b0;
      pb_meta_reg <= 1'b0;
      pb_sync_reg <= 1'b0;
      pb_prev_reg <= 1'b0;
    end else begin
      pa_meta_reg <= pin_a_in;
      pa_sync_reg <= pa_meta_reg;
      pa_prev_reg <= pa_sync_reg;
      pb_meta_reg <= pin_b_in;
      pb_sync_reg <= pb_meta_reg;
      pb_prev_reg <= pb_sync_reg;
    end
  end

  // prescaler: one tick every prescale_value+1 clocks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_cnt_reg <= 8'h00;
    end else if (pre_tick | ~timer_enable_bit) begin
      prescale_cnt_reg <= 8'h00;
    end else begin
      prescale_cnt_reg <= prescale_cnt_reg + 8'h01;
    end
  end

  // control, counters, reload/capture and flags
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ctrl_reg <= `MC_RESET;
      clock_ctrl_reg <= `CC_RESET;
      counter_one_reg <= `CNT_ZERO;
      counter_two_reg <= `CNT_ZERO;
      reload_capture_a_reg <= `CNT_ZERO;
      reload_capture_b_reg <= `CNT_ZERO;
      irq_enable_reg <= 4'h0;
      pending_reg <= 4'h0;
      pin_a_level_reg <= 1'b0;
      reload_from_b_reg <= 1'b0;
      train_run_reg <= 1'b0;
    end else begin
      // software side
      if (wr_mode) begin
        mode_ctrl_reg <= {wdata[`MC_PIN_A_OUT:`MC_EDGE_A], 1'b0,
          wdata[`MC_PT_SW_SEL:`MC_MODE_LO]};
        pin_a_level_reg <= wdata[`MC_PIN_A_OUT];
      end
      if (wr_clock) begin
        clock_ctrl_reg <= wdata[`CC_PRE_HI:`CC_SEL1_LO];
      end
      if (wr_rel_a) begin
        reload_capture_a_reg <= wdata[15:0];
      end
      if (wr_rel_b) begin
        reload_capture_b_reg <= wdata[15:0];
      end
      if (wr_ien) begin
        irq_enable_reg <= wdata[`PN_D:`PN_A];
      end
      if (wr_pend) begin
        pending_reg <= pending_reg & ~wdata[`PN_D:`PN_A];
      end

      // restart from no-clock or a fresh mode entry reloads from a first
      if ((clock_sel_one == `CK_NONE) | ~mode_pwm | train_start) begin
        reload_from_b_reg <= 1'b0;
      end
      if (train_start) begin
        train_run_reg <= 1'b1;
      end
      if (~mode_train) begin
        train_run_reg <= 1'b0;
      end

      // counter one
      if (mode_pwm & uf_one) begin
        counter_one_reg <= reload_from_b_reg ?
          reload_capture_b_reg : reload_capture_a_reg;
        reload_from_b_reg <= ~reload_from_b_reg;
        pin_a_level_reg <= ~pin_a_level_reg;
        if (reload_from_b_reg) begin
          pending_reg[`PN_B] <= 1'b1;
        end else begin
          pending_reg[`PN_A] <= 1'b1;
        end
      end else if (mode_dual & uf_one) begin
        counter_one_reg <= reload_capture_a_reg;
        pending_reg[`PN_A] <= 1'b1;
        if (pin_a_function_enable) begin
          pin_a_level_reg <= ~pin_a_level_reg;
        end
      end else if (mode_capture & uf_one) begin
        counter_one_reg <= `CNT_FULL;
        pending_reg[`PN_C] <= 1'b1;
      end else if (tick_one) begin
        counter_one_reg <= counter_one_reg - 16'h0001;
      end

      // dual capture with optional preset
      if (mode_capture & edge_a) begin
        reload_capture_a_reg <= counter_one_reg;
        pending_reg[`PN_A] <= 1'b1;
        if (pin_a_function_enable) begin
          counter_one_reg <= `CNT_FULL;
        end
      end
      if (mode_capture & edge_b) begin
        reload_capture_b_reg <= counter_one_reg;
        pending_reg[`PN_B] <= 1'b1;
        if (pin_b_function_enable) begin
          counter_one_reg <= `CNT_FULL;
        end
      end

      // counter two
      if (mode_train & uf_one) begin
        if (counter_two_reg == `CNT_ZERO) begin
          counter_two_reg <= `CNT_ZERO;
          pending_reg[`PN_D] <= 1'b1;
        end else begin
          counter_two_reg <= counter_two_reg - 16'h0001;
        end
      end else if (mode_dual & uf_two) begin
        counter_two_reg <= reload_capture_b_reg;
        pending_reg[`PN_D] <= 1'b1;
      end else if (uf_two) begin
        counter_two_reg <= `CNT_FULL;
        pending_reg[`PN_D] <= 1'b1;
      end else if (tick_two) begin
        counter_two_reg <= counter_two_reg - 16'h0001;
      end

      // train ends after counter_two+1 underflows of counter one
      if (train_end) begin
        train_run_reg <= 1'b0;
      end

      // software writes to the counters win over counting
      if (wr_cnt_one) begin
        counter_one_reg <= wdata[15:0];
      end
      if (wr_cnt_two) begin
        counter_two_reg <= wdata[15:0];
      end
    end
  end

  // read data, valid the cycle after the read strobe
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (rd_strobe) begin
      case (addr)
        `OFS_MODE_CTRL: rdata <= {21'h00000, pin_a_level_reg,
          mode_ctrl_reg[`MC_PIN_B_FN:`MC_MODE_LO]};
        `OFS_CLOCK_CTRL: rdata <= {16'h0000, clock_ctrl_reg};
        `OFS_COUNTER_ONE: rdata <= {16'h0000, counter_one_reg};
        `OFS_RELOAD_A: rdata <= {16'h0000, reload_capture_a_reg};
        `OFS_RELOAD_B: rdata <= {16'h0000, reload_capture_b_reg};
        `OFS_COUNTER_TWO: rdata <= {16'h0000, counter_two_reg};
        `OFS_IRQ_ENABLE: rdata <= {28'h0000000, irq_enable_reg};
        `OFS_PENDING: rdata <= {27'h0000000, train_run_reg, pending_reg};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // mftimer
`default_nettype wire

// file: hw/mftimer_consts.vh
/*
  register offsets, field positions, clock selector codes and reset
  values of the multifunction timer.
  assumes inclusion by bare name from the timer design file.
*/
`ifndef MFTIMER_CONSTS_VH
`define MFTIMER_CONSTS_VH
// register byte offsets
`define OFS_MODE_CTRL 8'h00
`define OFS_CLOCK_CTRL 8'h04
`define OFS_COUNTER_ONE 8'h08
`define OFS_RELOAD_A 8'h0c
`define OFS_RELOAD_B 8'h10
`define OFS_COUNTER_TWO 8'h14
`define OFS_IRQ_ENABLE 8'h18
`define OFS_PENDING 8'h1c
// mode control fields
`define MC_MODE_HI 1
`define MC_MODE_LO 0
`define MC_PT_EN 2
`define MC_TIMER_EN 3
`define MC_PT_SW_SEL 4
`define MC_PT_SW_TRIG 5
`define MC_EDGE_A 6
`define MC_EDGE_B 7
`define MC_PIN_A_FN 8
`define MC_PIN_B_FN 9
`define MC_PIN_A_OUT 10
`define MC_RESET 11'h000
// mode select codes
`define MODE_PWM 2'h0
`define MODE_CAPTURE 2'h1
`define MODE_DUAL 2'h2
// clock control fields
`define CC_SEL1_HI 2
`define CC_SEL1_LO 0
`define CC_SEL2_HI 6
`define CC_SEL2_LO 4
`define CC_PRE_HI 15
`define CC_PRE_LO 8
`define CC_RESET 16'h0000
// clock selector codes
`define CK_NONE 3'h0
`define CK_PRESCALED 3'h1
`define CK_EXT_EVENT 3'h2
`define CK_PULSE_ACC 3'h3
// pending / enable bits
`define PN_A 0
`define PN_B 1
`define PN_C 2
`define PN_D 3
// counter constants
`define CNT_ZERO 16'h0000
`define CNT_FULL 16'hffff
`endif

// file: tb/mftimer_monitor.sv
/*
  assertion checker for the timer's register port and outputs.
  assumes it is bound to mftimer and sees only that module's ports.
*/
`default_nettype none
module mftimer_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic pwm_output_pad,
  input wire logic irq_a,
  input wire logic irq_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  AST_RESET_QUIET: assert property (
    $rose(resetn) |-> !pwm_output_pad && !irq_a && !irq_b && rdata == 32'h0)
    else $error("outputs not quiet after reset");
  AST_CNT_WIDTH: assert property (
    $past(rd_strobe) && $past(addr) >= 8'h08 && $past(addr) <= 8'h14
    |-> rdata[31:16] == 16'h0) else $error("counter upper bits not zero");
  AST_TRIG_READS_ZERO: assert property (
    $past(rd_strobe) && $past(addr) == 8'h00 |-> !rdata[5])
    else $error("software trigger bit read back set");
  AST_PAD_LEVEL: assert property (
    wr_strobe && addr == 8'h00 |=> pwm_output_pad == $past(wdata[10]))
    else $error("pad level not taken from mode write");
  AST_IRQA_HOLD: assert property (
    irq_a && !wr_strobe |=> irq_a) else $error("irq a dropped without write");
  AST_IRQB_HOLD: assert property (
    irq_b && !wr_strobe |=> irq_b) else $error("irq b dropped without write");
  AST_MASK: assert property (
    wr_strobe && addr == 8'h18 && wdata[3:0] == 4'h0 |=> !irq_a && !irq_b)
    else $error("irq stayed high with all enables off");
  AST_UNMAPPED: assert property (
    $past(rd_strobe) && $past(addr) > 8'h1c |-> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // mftimer_monitor
bind mftimer mftimer_monitor mon (.sys_clk(sys_clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .rdata(rdata), .pwm_output_pad(pwm_output_pad), .irq_a(irq_a),
  .irq_b(irq_b));
`default_nettype wire

// file: tb/mftimer_pads.sv
/*
  model of the external signals on the selected capture pads.
  assumes the bench calls drive to change one pad level.
*/
`default_nettype none
module mftimer_pads (
  input wire logic sys_clk,
  output logic pin_a_in,
  output logic pin_b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_a_in = 1'b0;
    pin_b_in = 1'b0;
  end
  // level held four clocks, above the one clock minimum
  task automatic drive(input logic b, input logic lvl);
    @(posedge sys_clk);
    if (b) pin_b_in <= lvl;
    else pin_a_in <= lvl;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // mftimer_pads
`default_nettype wire

// file: tb/multifunction_timer_modes_tb_top.sv
/*
  self-checking bench: reset, pulse train, pin start, capture, dual timer.
  assumes mftimer, the pad model and the bound monitor are compiled.
*/
`default_nettype none
module multifunction_timer_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  wire [31:0] rdata;
  wire pin_a_in, pin_b_in, pwm_output_pad, irq_a, irq_b;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int tq[$];
  logic pad_q = 1'b0;
  logic [31:0] v, w;
  always #10 sys_clk = ~sys_clk;
  // stamps every pad change with the clock count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pad_q <= pwm_output_pad;
    if (pwm_output_pad !== pad_q) tq.push_back(cyc);
  end
  mftimer uut (.sys_clk(sys_clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rdata(rdata), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .pwm_output_pad(pwm_output_pad), .irq_a(irq_a), .irq_b(irq_b));
  mftimer_pads pads (.sys_clk(sys_clk), .pin_a_in(pin_a_in),
    .pin_b_in(pin_b_in));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    rd(8'h00, v);
    chk("mode after reset", 32'h0, v);
    w = {29'h0, pwm_output_pad, irq_a, irq_b};
    chk("outputs after reset", 32'h0, w);
  endtask
  task automatic t_train;
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'hb);
    wr(8'h00, 32'h41c);
    chk("initial level", 1'b1, pwm_output_pad);
    wr(8'h00, 32'h43c);
    // the initial-level change is stamped one edge late; drop it here
    tq.delete();
    repeat (60) @(posedge sys_clk);
    chk("train pulses", 32'd3, tq.size());
    chk("gap after a", 32'd4, tq[1] - tq[0]);
    chk("gap after b", 32'd2, tq[2] - tq[1]);
    chk("final level", 1'b0, pwm_output_pad);
    rd(8'h14, v);
    chk("counter two end", 32'h0, v);
    rd(8'h1c, v);
    chk("train pending", 32'hb, v);
    chk("irq both", 2'h3, {irq_a, irq_b});
    wr(8'h18, 32'h0);
    chk("irq masked", 2'h0, {irq_a, irq_b});
    wr(8'h1c, 32'hf);
    wr(8'h18, 32'hf);
    chk("irq cleared", 2'h0, {irq_a, irq_b});
  endtask
  task automatic t_pinb;
    wr(8'h14, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h48c);
    pads.drive(1'b1, 1'b1);
    tq.delete();
    repeat (10) @(posedge sys_clk);
    chk("wrong edge start", 32'd0, tq.size());
    pads.drive(1'b1, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk("one pulse", 32'd1, tq.size());
  endtask
  task automatic t_cap;
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h1000);
    wr(8'h1c, 32'hf);
    wr(8'h00, 32'h109);
    pads.drive(1'b0, 1'b1);
    rd(8'h0c, v);
    chk("capture a", 1'b1, v <= 32'h1000 && v > 32'hf00);
    rd(8'h08, v);
    chk("preset", 1'b1, v > 32'hff00);
    pads.drive(1'b1, 1'b1);
    rd(8'h10, v);
    chk("capture b", 1'b1, v > 32'hff00 && v < 32'h10000);
    rd(8'h1c, v);
    chk("capture pending", 4'h3, v[3:0]);
    // pulse accumulate with pin b held active would count if not stopped
    wr(8'h04, 32'h3);
    rd(8'h08, v);
    repeat (5) @(posedge sys_clk);
    rd(8'h08, w);
    chk("pin clock stops one", v, w);
  endtask
  task automatic t_dual;
    wr(8'h00, 32'h10a);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h4);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h2);
    wr(8'h1c, 32'hf);
    wr(8'h18, 32'h8);
    wr(8'h04, 32'h11);
    tq.delete();
    repeat (40) @(posedge sys_clk);
    chk("half period 1", 32'd5, tq[1] - tq[0]);
    chk("half period 2", 32'd5, tq[2] - tq[1]);
    chk("irq only b", 2'h1, {irq_a, irq_b});
    rd(8'h1c, v);
    chk("dual pending", 4'h9, v[3:0]);
    rd(8'h20, v);
    chk("unmapped", 32'h0, v);
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_train();
    t_pinb();
    t_cap();
    t_dual();
    end_of_test();
  end
endmodule // multifunction_timer_modes_tb_top
`default_nettype wire
